// ===== logic/gpb_pkg.sv
// constants and register map of the general purpose port bank
package gpb_pkg;

    // bank geometry
    localparam int NUM_BANKS    = 7;
    localparam int BANK_W       = 8;
    localparam int BANK_G       = 6;
    localparam int BANK_G_W     = 5;
    localparam int NUM_PINS     = BANK_G * BANK_W + BANK_G_W;

    // register bus
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 8;
    localparam int REGS_PER_BANK = 3;

    // register kinds inside one bank
    localparam logic [1:0] KIND_LATCH = 2'h0;
    localparam logic [1:0] KIND_DIR   = 2'h1;
    localparam logic [1:0] KIND_LEVEL = 2'h2;

    // reset values and implemented bit masks
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET   = 8'h00;
    localparam logic [7:0] FULL_MASK   = 8'hff;
    localparam logic [7:0] G_MASK      = 8'h1f;
    localparam logic [7:0] READ_NONE   = 8'h00;

    // bank g pin positions inside the bank
    localparam int PG_OSC_IN  = 4;
    localparam int PG_OSC_OUT = 3;
    localparam int PG_ALE     = 2;
    localparam int PG_RDS     = 1;
    localparam int PG_WRS     = 0;

    // byte address of a register: bank times three plus kind
    function automatic logic [ADDR_W-1:0] reg_addr(input int bank, input logic [1:0] kind);
        reg_addr = ADDR_W'(bank * REGS_PER_BANK + int'(kind));
    endfunction : reg_addr

    // implemented bits of a bank
    function automatic logic [7:0] bank_mask(input int bank);
        bank_mask = (bank == BANK_G) ? G_MASK : FULL_MASK;
    endfunction : bank_mask

endpackage : gpb_pkg

// ===== logic/gpb_port_bank.sv
// seven port banks with latch, direction, pin level and bank g overrides
`timescale 1ns/1ns
module gpb_port_bank (
    input  wire logic                          I_SYS_CLK,
    input  wire logic                          I_RST,
    input  wire logic [gpb_pkg::ADDR_W-1:0]    I_ADDR,
    input  wire logic [gpb_pkg::DATA_W-1:0]    I_WDATA,
    input  wire logic                          I_WR,
    input  wire logic                          I_RD,
    output logic      [gpb_pkg::DATA_W-1:0]    O_RDATA,
    input  wire logic [gpb_pkg::NUM_PINS-1:0]  I_PIN_IN,
    output logic      [gpb_pkg::NUM_PINS-1:0]  O_PIN_OUT,
    output logic      [gpb_pkg::NUM_PINS-1:0]  O_PIN_OE,
    output logic      [gpb_pkg::NUM_PINS-1:0]  O_PIN_PULLUP,
    output logic      [gpb_pkg::NUM_PINS-1:0]  O_PIN_INPUT_DISABLE,
    input  wire logic                          I_ASYNC_TIMER_CLOCK_SELECT,
    input  wire logic                          I_EXTERNAL_CLOCK_SELECT,
    input  wire logic                          I_EXT_MEMORY_ENABLE,
    input  wire logic                          I_EXT_MEM_ALE,
    input  wire logic                          I_EXT_MEM_RD_STROBE,
    input  wire logic                          I_EXT_MEM_WR_STROBE
);

    localparam int NP = gpb_pkg::NUM_PINS;
    localparam int NB = gpb_pkg::NUM_BANKS;
    localparam int GB = gpb_pkg::BANK_G * gpb_pkg::BANK_W;

    // flat pin numbers of the bank g pins
    localparam int P_OSC_IN  = GB + gpb_pkg::PG_OSC_IN;
    localparam int P_OSC_OUT = GB + gpb_pkg::PG_OSC_OUT;
    localparam int P_ALE     = GB + gpb_pkg::PG_ALE;
    localparam int P_RDS     = GB + gpb_pkg::PG_RDS;
    localparam int P_WRS     = GB + gpb_pkg::PG_WRS;

    typedef struct packed {
        logic [NB-1:0][7:0] latch;
        logic [NB-1:0][7:0] dir;
        logic [NB-1:0][7:0] level;
        logic [NP-1:0]      sync1;
        logic [NP-1:0]      sync2;
        logic [NP-1:0]      pin_out;
        logic [NP-1:0]      pin_oe;
        logic [NP-1:0]      pin_pu;
        logic [NP-1:0]      pin_dis;
        logic [7:0]         rdata;
    } gpb_state_t;

    gpb_state_t state_reg;
    gpb_state_t state_next;

    // override controls, one bit per flat pin
    logic [NP-1:0] pu_ovr_en;
    logic [NP-1:0] pu_ovr_val;
    logic [NP-1:0] dir_ovr_en;
    logic [NP-1:0] dir_ovr_val;
    logic [NP-1:0] out_ovr_en;
    logic [NP-1:0] out_ovr_val;
    logic [NP-1:0] dis_ovr_en;
    logic [NP-1:0] dis_ovr_val;

    // register-derived and final pin controls
    logic [NP-1:0] reg_latch;
    logic [NP-1:0] reg_dir;
    logic [NP-1:0] eff_pu;
    logic [NP-1:0] eff_dir;
    logic [NP-1:0] eff_out;
    logic [NP-1:0] eff_dis;

    logic async_sel;
    logic ext_clk;
    logic mem_en;
    assign async_sel = I_ASYNC_TIMER_CLOCK_SELECT;
    assign ext_clk   = I_EXTERNAL_CLOCK_SELECT;
    assign mem_en    = I_EXT_MEMORY_ENABLE;

    // override table of bank g, all other pins free of overrides
    always_comb begin
        pu_ovr_en   = '0;
        pu_ovr_val  = '0;
        dir_ovr_en  = '0;
        dir_ovr_val = '0;
        out_ovr_en  = '0;
        out_ovr_val = '0;
        dis_ovr_en  = '0;
        dis_ovr_val = '0;
        // async select takes g4 from the port, and g3 only when external clock select is also set
        pu_ovr_en[P_OSC_IN]   = async_sel;
        dir_ovr_en[P_OSC_IN]  = async_sel;
        dis_ovr_en[P_OSC_IN]  = async_sel;
        dis_ovr_val[P_OSC_IN] = ext_clk;
        pu_ovr_en[P_OSC_OUT]  = async_sel & ext_clk;
        dir_ovr_en[P_OSC_OUT] = async_sel & ext_clk;
        dis_ovr_en[P_OSC_OUT] = async_sel;
        // memory strobes own g2..g0 as outputs
        pu_ovr_en[P_ALE:P_WRS]   = {3{mem_en}};
        dir_ovr_en[P_ALE:P_WRS]  = {3{mem_en}};
        dir_ovr_val[P_ALE:P_WRS] = {3{1'b1}};
        out_ovr_en[P_ALE:P_WRS]  = {3{mem_en}};
        out_ovr_val[P_ALE] = I_EXT_MEM_ALE;
        out_ovr_val[P_RDS] = I_EXT_MEM_RD_STROBE;
        out_ovr_val[P_WRS] = I_EXT_MEM_WR_STROBE;
    end

    // per pin control mux
    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_pin
            localparam int B = gp / gpb_pkg::BANK_W;
            localparam int I = gp % gpb_pkg::BANK_W;
            assign reg_latch[gp] = state_reg.latch[B][I];
            assign reg_dir[gp]   = state_reg.dir[B][I];
            // direction one drives latch, zero is input
            assign eff_dir[gp] = dir_ovr_en[gp] ? dir_ovr_val[gp] : reg_dir[gp];
            assign eff_out[gp] = out_ovr_en[gp] ? out_ovr_val[gp] : reg_latch[gp];
            assign eff_pu[gp]  = pu_ovr_en[gp] ? pu_ovr_val[gp]
                                               : (reg_latch[gp] & ~reg_dir[gp]);
            assign eff_dis[gp] = dis_ovr_en[gp] & dis_ovr_val[gp];
        end
    endgenerate

    // next state: sampling, register writes, pin controls, read data
    always_comb begin
        logic [7:0] mask;
        logic [7:0] rd_val;
        int         p;
        mask       = gpb_pkg::FULL_MASK;
        rd_val     = gpb_pkg::READ_NONE;
        p          = 0;
        state_next = state_reg;
        // two stage synchroniser on every pin input
        state_next.sync1 = I_PIN_IN;
        state_next.sync2 = state_reg.sync1;
        for (int b = 0; b < NB; b++) begin
            mask = gpb_pkg::bank_mask(b);
            // pin level follows synchronised pins, disabled inputs read zero
            // bank g upper bits stay zero
            for (int i = 0; i < gpb_pkg::BANK_W; i++) begin
                p = b * gpb_pkg::BANK_W + i;
                if (mask[i]) begin
                    state_next.level[b][i] = state_reg.sync2[p] & ~eff_dis[p];
                end else begin
                    state_next.level[b][i] = 1'b0;
                end
            end
            // latch write, bank g upper bits held zero
            if (I_WR && I_ADDR == gpb_pkg::reg_addr(b, gpb_pkg::KIND_LATCH)) begin
                state_next.latch[b] = I_WDATA & mask;
            end
            // direction write, bank g upper bits held zero
            if (I_WR && I_ADDR == gpb_pkg::reg_addr(b, gpb_pkg::KIND_DIR)) begin
                state_next.dir[b] = I_WDATA & mask;
            end
            // writing ones to the level register toggles latch bits
            if (I_WR && I_ADDR == gpb_pkg::reg_addr(b, gpb_pkg::KIND_LEVEL)) begin
                state_next.latch[b] = state_reg.latch[b] ^ (I_WDATA & mask);
            end
            if (I_ADDR == gpb_pkg::reg_addr(b, gpb_pkg::KIND_LATCH)) begin
                rd_val = state_reg.latch[b];
            end
            if (I_ADDR == gpb_pkg::reg_addr(b, gpb_pkg::KIND_DIR)) begin
                rd_val = state_reg.dir[b];
            end
            if (I_ADDR == gpb_pkg::reg_addr(b, gpb_pkg::KIND_LEVEL)) begin
                rd_val = state_reg.level[b];
            end
        end
        // read data only in the cycle after the read strobe
        state_next.rdata = I_RD ? rd_val : gpb_pkg::READ_NONE;
        // registered pin controls, oe only when direction is output
        state_next.pin_out = eff_out & eff_dir;
        state_next.pin_oe  = eff_dir;
        state_next.pin_pu  = eff_pu & ~eff_dir;
        state_next.pin_dis = eff_dis;
    end

    // state register
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_reg       <= '0;
            state_reg.latch <= {NB{gpb_pkg::LATCH_RESET}};
            state_reg.dir   <= {NB{gpb_pkg::DIR_RESET}};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign O_RDATA             = state_reg.rdata;
    assign O_PIN_OUT           = state_reg.pin_out;
    assign O_PIN_OE            = state_reg.pin_oe;
    assign O_PIN_PULLUP        = state_reg.pin_pu;
    assign O_PIN_INPUT_DISABLE = state_reg.pin_dis;

    // checks on pin overrides and registers
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    sequence s_pin_a0_stable;
        !I_WR ##0 $stable(I_PIN_IN[0])[*3];
    endsequence

    sequence s_write_latch_a;
        I_WR && I_ADDR == gpb_pkg::reg_addr(0, gpb_pkg::KIND_LATCH);
    endsequence

    sequence s_read_latch_a;
        I_RD && !I_WR && I_ADDR == gpb_pkg::reg_addr(0, gpb_pkg::KIND_LATCH);
    endsequence

    // write to the bank g latch
    sequence s_write_g_latch;
        I_WR && I_ADDR == gpb_pkg::reg_addr(gpb_pkg::BANK_G, gpb_pkg::KIND_LATCH);
    endsequence

    // write to the bank a level address
    sequence s_toggle_a;
        I_WR && I_ADDR == gpb_pkg::reg_addr(0, gpb_pkg::KIND_LEVEL);
    endsequence

    // read of an address past the last bank
    sequence s_read_unmapped;
        I_RD && I_ADDR > gpb_pkg::reg_addr(gpb_pkg::NUM_BANKS - 1, gpb_pkg::KIND_LEVEL);
    endsequence

    a_osc_in_held: assert property (
        async_sel |=> !O_PIN_OE[P_OSC_IN] && !O_PIN_PULLUP[P_OSC_IN]
                      && O_PIN_INPUT_DISABLE[P_OSC_IN] == $past(ext_clk))
        else $error("osc input pin not overridden");

    a_osc_out_held: assert property (
        (async_sel && ext_clk) |=> !O_PIN_OE[P_OSC_OUT] && !O_PIN_PULLUP[P_OSC_OUT]
                                   && !O_PIN_INPUT_DISABLE[P_OSC_OUT])
        else $error("osc output pin not overridden");

    a_osc_out_free: assert property (
        (async_sel && !ext_clk) |=> O_PIN_OE[P_OSC_OUT] == $past(reg_dir[P_OSC_OUT]))
        else $error("osc output pin direction wrongly forced");

    a_osc_port_gone: assert property (
        (async_sel && ext_clk)[*2] |=> state_reg.level[gpb_pkg::BANK_G][gpb_pkg::PG_OSC_IN] == 1'b0)
        else $error("osc input still reaches the port");

    a_mem_pins_out: assert property (
        mem_en |=> O_PIN_OE[P_ALE:P_WRS] == 3'h7 && O_PIN_PULLUP[P_ALE:P_WRS] == 3'h0
                   && O_PIN_INPUT_DISABLE[P_ALE:P_WRS] == 3'h0)
        else $error("memory strobe pins not outputs");

    a_mem_write_strobe: assert property (
        mem_en |=> O_PIN_OUT[P_WRS] == $past(I_EXT_MEM_WR_STROBE))
        else $error("write strobe not on pin g0");

    a_mem_ale_strobe: assert property (
        mem_en |=> O_PIN_OUT[P_ALE] == $past(I_EXT_MEM_ALE))
        else $error("address latch strobe not on pin g2");

    a_mem_read_strobe: assert property (
        mem_en |=> O_PIN_OUT[P_RDS] == $past(I_EXT_MEM_RD_STROBE))
        else $error("read strobe not on pin g1");

    a_latch_readback: assert property (
        s_write_latch_a ##1 s_read_latch_a |=> O_RDATA == $past(I_WDATA, 2))
        else $error("latch a readback mismatch");

    a_dir_drives_pin: assert property (
        (I_WR && I_ADDR == gpb_pkg::reg_addr(0, gpb_pkg::KIND_DIR))
        ##1 (!I_WR)[*2] |=> O_PIN_OE[0] == $past(I_WDATA[0], 3)
                            && O_PIN_OUT[0] == ($past(I_WDATA[0], 3) & reg_latch[0]))
        else $error("direction bit does not steer pin a0");

    a_dir_write: assert property (
        (I_WR && I_ADDR == gpb_pkg::reg_addr(1, gpb_pkg::KIND_DIR))
        |=> state_reg.dir[1] == $past(I_WDATA))
        else $error("direction b not written");

    a_level_follow: assert property (
        s_pin_a0_stable |=> O_PIN_INPUT_DISABLE[0] || state_reg.level[0][0] == $past(I_PIN_IN[0]))
        else $error("pin level a0 does not follow pin");

    a_g_latch_upper: assert property (
        (I_RD && I_ADDR == gpb_pkg::reg_addr(gpb_pkg::BANK_G, gpb_pkg::KIND_LATCH))
        |=> O_RDATA[7:5] == 3'h0)
        else $error("bank g latch upper bits not zero");

    a_g_dir_upper: assert property (
        (I_RD && I_ADDR == gpb_pkg::reg_addr(gpb_pkg::BANK_G, gpb_pkg::KIND_DIR))
        |=> O_RDATA[7:5] == 3'h0)
        else $error("bank g direction upper bits not zero");

    a_g_level_upper: assert property (
        (I_RD && I_ADDR == gpb_pkg::reg_addr(gpb_pkg::BANK_G, gpb_pkg::KIND_LEVEL))
        |=> O_RDATA[7:5] == 3'h0)
        else $error("bank g level upper bits not zero");

    a_override_free: assert property (
        !mem_en && !async_sel |=> O_PIN_OE[P_OSC_IN:P_WRS] == $past(reg_dir[P_OSC_IN:P_WRS]))
        else $error("bank g pins overridden with no enable");

    // read data returns to zero without a read
    a_rdata_quiet: assert property (
        !I_RD |=> O_RDATA == gpb_pkg::READ_NONE)
        else $error("read data not zero after idle cycle");

    a_unmapped_read: assert property (
        s_read_unmapped |=> O_RDATA == gpb_pkg::READ_NONE)
        else $error("unmapped address read not zero");

    // no pin below g3 may disable its input
    a_dis_only_osc: assert property (
        O_PIN_INPUT_DISABLE[P_OSC_OUT-1:0] == '0)
        else $error("input disable on a pin without override");

    // no pull-up on a driven pin
    a_pullup_not_out: assert property (
        (O_PIN_PULLUP & O_PIN_OE) == '0)
        else $error("pull-up on while pin is an output");

    a_out_needs_oe: assert property (
        (O_PIN_OUT & ~O_PIN_OE) == '0)
        else $error("drive value on a pin that is not an output");

    // bank g latch upper bits never set
    a_g_latch_mask: assert property (
        state_reg.latch[gpb_pkg::BANK_G][7:5] == 3'h0)
        else $error("bank g latch upper bits set");

    // bank g direction upper bits never set
    a_g_dir_mask: assert property (
        state_reg.dir[gpb_pkg::BANK_G][7:5] == 3'h0)
        else $error("bank g direction upper bits set");

    // bank g level upper bits never set
    a_g_level_mask: assert property (
        state_reg.level[gpb_pkg::BANK_G][7:5] == 3'h0)
        else $error("bank g level upper bits set");

    // bank g latch write keeps only implemented bits
    a_g_write_masked: assert property (
        s_write_g_latch |=> state_reg.latch[gpb_pkg::BANK_G]
                            == ($past(I_WDATA) & gpb_pkg::G_MASK))
        else $error("bank g latch write not masked");

    // level address write toggles latch bits
    a_level_toggle: assert property (
        s_toggle_a |=> state_reg.latch[0] == ($past(state_reg.latch[0]) ^ $past(I_WDATA)))
        else $error("level write did not toggle latch a");

endmodule : gpb_port_bank

// ===== sim/gpb_pin_model.sv
// model of the circuitry outside the port pins
`timescale 1ns/1ns
module gpb_pin_model (
    input  wire logic                          i_clk,
    input  wire logic [gpb_pkg::NUM_PINS-1:0]  i_ext_val,
    input  wire logic [gpb_pkg::NUM_PINS-1:0]  i_ext_en,
    input  wire logic [gpb_pkg::NUM_PINS-1:0]  i_pin_out,
    input  wire logic [gpb_pkg::NUM_PINS-1:0]  i_pin_oe,
    input  wire logic [gpb_pkg::NUM_PINS-1:0]  i_pin_pullup,
    output logic      [gpb_pkg::NUM_PINS-1:0]  o_pin_in
);
    logic phase_reg = 1'b0;

    // floating pins wander every cycle so a stale level never passes
    always_ff @(posedge i_clk) begin
        phase_reg <= ~phase_reg;
    end

    // device drive wins, then outside drive, then pull-up, else floating
    always_comb begin
        o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext_val)
                 | (~i_pin_oe & ~i_ext_en & (i_pin_pullup | {gpb_pkg::NUM_PINS{phase_reg}}));
    end
endmodule : gpb_pin_model

// ===== sim/tb_gpb_port_bank.sv
// self-checking bench: registers, pin drive and bank g overrides
`timescale 1ns/1ns
module tb_gpb_port_bank;
    localparam int NP = gpb_pkg::NUM_PINS;
    logic          I_SYS_CLK, I_RST, I_WR, I_RD, I_ASYNC, I_EXTCLK, I_MEM, I_ALE, I_RDS, I_WRS;
    logic [7:0]    I_ADDR, I_WDATA, O_RDATA;
    logic [NP-1:0] I_PIN_IN, O_PIN_OUT, O_PIN_OE, O_PIN_PULLUP, O_PIN_IDIS, ext_val, ext_en;
    int            miscompares = 0;
    int            cmp_count = 0;
    logic [31:0]   rnd;
    logic [7:0]    exp_q[$];
    logic [7:0]    lat[7];
    logic [7:0]    dir[7];
    logic          rd_seen = 1'b0;

    gpb_port_bank i_dut (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PIN_IN(I_PIN_IN),
        .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE), .O_PIN_PULLUP(O_PIN_PULLUP),
        .O_PIN_INPUT_DISABLE(O_PIN_IDIS), .I_ASYNC_TIMER_CLOCK_SELECT(I_ASYNC),
        .I_EXTERNAL_CLOCK_SELECT(I_EXTCLK), .I_EXT_MEMORY_ENABLE(I_MEM), .I_EXT_MEM_ALE(I_ALE),
        .I_EXT_MEM_RD_STROBE(I_RDS), .I_EXT_MEM_WR_STROBE(I_WRS));
    gpb_pin_model i_pins (.i_clk(I_SYS_CLK), .i_ext_val(ext_val),
        .i_ext_en(ext_en), .i_pin_out(O_PIN_OUT), .i_pin_oe(O_PIN_OE),
        .i_pin_pullup(O_PIN_PULLUP), .o_pin_in(I_PIN_IN));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // expected bank g controls: {oe, out, pullup, input disable}
    function automatic logic [19:0] exp_g(input logic [4:0] d, input logic as, ex, me, al, rs, ws);
        logic [4:0] dd_oe, pv_oe, oe, val;
        dd_oe = {as, as & ex, me, me, me};
        pv_oe = {2'b00, me, me, me};
        oe    = (dd_oe & 5'h07) | (~dd_oe & d);
        val   = (pv_oe & {2'b00, al, rs, ws}) | (~pv_oe & 5'h1f);
        exp_g = {oe, val & oe, ~dd_oe & ~oe, as & ex, 4'h0};
    endfunction : exp_g

    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0 && exp_q.size() == 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t read exp %h got %h", $time, exp, got);
        end
    endtask : cmp8

    task automatic cmp_pins(input logic [NP-1:0] exp, input logic [NP-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t pins exp %h got %h", $time, exp, got);
        end
    endtask : cmp_pins

    // one bus cycle; a read notes its expected data for the monitor
    task automatic bus_op(input logic wr_op, input logic [7:0] a, input logic [7:0] d);
        I_WR    <= wr_op;
        I_RD    <= ~wr_op;
        I_ADDR  <= a;
        I_WDATA <= d;
        if (!wr_op) exp_q.push_back(d);
        @(posedge I_SYS_CLK);
    endtask : bus_op

    task automatic idle(input int n);
        I_WR <= 1'b0;
        I_RD <= 1'b0;
        repeat (n) @(posedge I_SYS_CLK);
    endtask : idle

    task automatic do_reset();
        I_RST <= 1'b1;
        repeat (6) @(posedge I_SYS_CLK);
        I_RST <= 1'b0;
        @(posedge I_SYS_CLK);
    endtask : do_reset

    // read data stands in the cycle after the strobe
    always @(posedge I_SYS_CLK) begin
        rd_seen <= I_RD & ~I_RST;
    end

    // compare mid-cycle, where the read data is settled
    always @(negedge I_SYS_CLK) begin
        if (rd_seen) cmp8(exp_q.pop_front(), O_RDATA);
    end

    initial begin
        I_SYS_CLK = 1'b0;
        forever #5 I_SYS_CLK = ~I_SYS_CLK;
    end

    initial begin
        repeat (20000) @(posedge I_SYS_CLK);
        miscompares++;
        end_of_test();
    end

    initial begin
        logic [55:0] ev, eo, eu, ep;
        logic [19:0] eg;
        {I_RST, I_WR, I_RD, I_ADDR, I_WDATA} = {3'b100, 16'h0000};
        {I_ASYNC, I_EXTCLK, I_MEM, I_ALE, I_RDS, I_WRS} = 6'h00;
        {ext_val, ext_en} = '0;
        rnd = 32'h932ccd17;
        do_reset();
        // reset values of latches and directions
        for (int b = 0; b < 7; b++) begin
            bus_op(1'b0, gpb_pkg::reg_addr(b, gpb_pkg::KIND_LATCH), 8'h00);
            bus_op(1'b0, gpb_pkg::reg_addr(b, gpb_pkg::KIND_DIR), 8'h00);
        end
        // outside drive seen through the level registers
        rnd = lfsr(rnd);
        ev = {rnd[23:0], lfsr(rnd)};
        ext_val <= ev[NP-1:0];
        ext_en <= '1;
        idle(4);
        for (int b = 0; b < 7; b++) begin
            bus_op(1'b0, gpb_pkg::reg_addr(b, gpb_pkg::KIND_LEVEL),
                ev[b*8+:8] & gpb_pkg::bank_mask(b));
        end
        ext_en <= '0;
        // random latch and direction, back to back writes and reads
        for (int b = 0; b < 7; b++) begin
            rnd = lfsr(rnd);
            lat[b] = rnd[7:0] & gpb_pkg::bank_mask(b);
            dir[b] = rnd[15:8] & gpb_pkg::bank_mask(b);
            bus_op(1'b1, gpb_pkg::reg_addr(b, gpb_pkg::KIND_LATCH), rnd[7:0]);
            bus_op(1'b1, gpb_pkg::reg_addr(b, gpb_pkg::KIND_DIR), rnd[15:8]);
            bus_op(1'b0, gpb_pkg::reg_addr(b, gpb_pkg::KIND_LATCH), lat[b]);
            bus_op(1'b0, gpb_pkg::reg_addr(b, gpb_pkg::KIND_DIR), dir[b]);
            eo[b*8+:8] = dir[b];
            eu[b*8+:8] = lat[b] & dir[b];
            ep[b*8+:8] = lat[b] & ~dir[b];
        end
        idle(3);
        #1;
        cmp_pins(eo[NP-1:0], O_PIN_OE);
        cmp_pins(eu[NP-1:0], O_PIN_OUT);
        cmp_pins(ep[NP-1:0], O_PIN_PULLUP);
        cmp_pins('0, O_PIN_IDIS);
        // writing ones to a level address toggles the latch; unmapped place
        bus_op(1'b1, gpb_pkg::reg_addr(0, gpb_pkg::KIND_LEVEL), 8'h0f);
        bus_op(1'b1, 8'h15, 8'hff);
        bus_op(1'b0, gpb_pkg::reg_addr(0, gpb_pkg::KIND_LATCH), lat[0] ^ 8'h0f);
        bus_op(1'b0, 8'h15, gpb_pkg::READ_NONE);
        bus_op(1'b1, gpb_pkg::reg_addr(6, gpb_pkg::KIND_LATCH), 8'hff);
        bus_op(1'b0, gpb_pkg::reg_addr(6, gpb_pkg::KIND_LATCH), gpb_pkg::G_MASK);
        // every select combination over both directions of bank g
        for (int p = 0; p < 2; p++) begin
            bus_op(1'b1, gpb_pkg::reg_addr(6, gpb_pkg::KIND_DIR), p ? 8'h00 : 8'hff);
            if (p == 0) bus_op(1'b0, gpb_pkg::reg_addr(6, gpb_pkg::KIND_DIR), 8'h1f);
            for (int k = 0; k < 8; k++) begin
                rnd = lfsr(rnd);
                {I_MEM, I_EXTCLK, I_ASYNC} <= k[2:0];
                {I_ALE, I_RDS, I_WRS} <= rnd[2:0];
                idle(3);
                #1;
                eg = exp_g(p ? 5'h00 : 5'h1f, k[0], k[1], k[2], rnd[2], rnd[1], rnd[0]);
                cmp_pins(NP'(eg[19:15]), NP'(O_PIN_OE[52:48]));
                cmp_pins(NP'(eg[14:10]), NP'(O_PIN_OUT[52:48]));
                cmp_pins(NP'(eg[9:5]), NP'(O_PIN_PULLUP[52:48]));
                cmp_pins(NP'(eg[4:0]), NP'(O_PIN_IDIS[52:48]));
            end
        end
        {I_MEM, I_EXTCLK, I_ASYNC, I_ALE, I_RDS, I_WRS} <= 6'h00;
        // reset in mid-run clears the registers again
        do_reset();
        bus_op(1'b0, gpb_pkg::reg_addr(0, gpb_pkg::KIND_LATCH), 8'h00);
        bus_op(1'b0, gpb_pkg::reg_addr(6, gpb_pkg::KIND_DIR), 8'h00);
        idle(3);
        end_of_test();
    end
endmodule : tb_gpb_port_bank
